// ===== src/ddc_pkg.sv
/*
 * ddc_pkg: shared constants and carrier types for the display data
 * channel slave. assumes an 8-bit special-function register port.
 */
package ddc_pkg;
   // special-function register addresses
   localparam logic [7:0] ADDR_HOLD_DDC = 8'h00_D1; // ddc path hold
   localparam logic [7:0] ADDR_HOLD_I2C = 8'h00_D2; // i2c path hold
   localparam logic [7:0] ADDR_RAM_BUFFER_WINDOW   = 8'h00_D4; // ram window
   localparam logic [7:0] ADDR_TXBYTE   = 8'h00_D5; // vsync tx byte
   localparam logic [7:0] ADDR_PTR      = 8'h00_D6; // sram pointer
   localparam logic [7:0] ADDR_CTRL     = 8'h00_D7; // channel control
   localparam logic [7:0] ADDR_I2C_CTL  = 8'h00_D8; // i2c1 control
   localparam logic [7:0] ADDR_I2C_STA  = 8'h00_D9; // i2c1 status
   localparam logic [7:0] ADDR_I2C_DAT  = 8'h00_DA; // i2c1 shift byte
   localparam logic [7:0] ADDR_I2C_ADR  = 8'h00_DB; // i2c1 own address
   // reset values
   localparam logic [7:0] RST_ZERO      = 8'h00_00;
   // control register fields
   localparam int CTL_SIZE  = 6; // sram size select
   localparam int CTL_SW    = 5; // software mode select
   localparam int CTL_WIDE  = 4; // wide address match
   localparam int CTL_VIRQ  = 3; // vsync mode irq
   localparam int CTL_VEN   = 2; // vsync mode enable
   localparam int CTL_SWIRQ = 1; // mode switch irq
   localparam int CTL_MODE  = 0; // current mode flag
   localparam logic [7:0] CTL_WMASK = 8'h00_74; // software-writable
   // i2c1 control fields
   localparam int I2C_EN    = 6; // interface enable
   localparam int I2C_AA    = 2; // acknowledge enable
   // hold register fields
   localparam int HOLD_EN   = 7;
   // monitor-data address a0/a1 (7-bit 0x50)
   localparam logic [6:0] DDC_SLAVE = 7'h50;
   // sample clock is mclk/2
   localparam logic [0:0] SAMPLE_DIV = 1'h1;
   // vsync bits per byte (8 data + 1 idle)
   localparam logic [3:0] VBITS = 4'h8;
   // fifo geometry
   localparam int FIFO_W = 8;
   localparam int FIFO_D = 16;

   // processor register port
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ddc_sfr_req_t;

   // serial link pin samples
   typedef struct packed {
      logic sda;
      logic scl;
      logic vsync;
   } ddc_pins_t;
endpackage : ddc_pkg

// ===== src/ddc_fifo.sv
/*
 * ddc_fifo: small synchronous fifo with valid/ready on both sides.
 * assumes one clock and synchronous active-high reset.
 */
module ddc_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   // state in one packed struct
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } ddc_fifo_st_t;
   ddc_fifo_st_t st, next_st;
   logic [W-1:0] mem [D];   // storage array
   logic         push, pop; // handshakes

   assign in_ready  = (st.cnt != (AW+1)'(D));
   assign out_valid = (st.cnt != '0);
   assign out_data  = mem[st.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // pointer and count update
   always_comb begin
      next_st = st;
      if (push) next_st.wp = st.wp + 1'b1;
      if (pop)  next_st.rp = st.rp + 1'b1;
      next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   // registered state and write port
   always_ff @(posedge mclk) begin
      if (sys_rst) st <= '0;
      else         st <= next_st;
      if (push) mem[st.wp] <= in_data;
   end

   a_fifo_no_over: assert property (@(posedge mclk) disable iff (sys_rst)
      st.cnt <= (AW+1)'(D)) else $error("fifo overfilled");
endmodule : ddc_fifo

// ===== src/ddc_slave.sv
/*
 * ddc_slave: display data channel slave with 256-byte sram, vsync
 * transmit-only mode and i2c read mode. assumes pins and register
 * strobes synchronous to mclk; open-drain pins resolved outside.
 */
module ddc_slave (
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   input  wire ddc_pkg::ddc_sfr_req_t sfr,     // register request
   output logic [7:0]             sfr_rdata,   // register read data
   input  wire ddc_pkg::ddc_pins_t pins,       // port4 bits 0,1,2
   output logic                   p4_0_out,    // sda drive level
   output logic                   p4_0_oe_n,   // sda enable, low=drive
   output logic                   irq          // ddc/i2c event request
);
   // link states
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_TX, S_TACK,
                             S_RX, S_RACK} ddc_st_e_t;
   // all state of the block except the sram and the fifo
   typedef struct packed {
      logic [7:0] hold_ddc, hold_i2c, txb, ptr, ctl;
      logic [7:0] i2c_ctl, i2c_sta, shift, own;
      logic       div;                    // sample clock divider
      logic [7:0] hcnt;                   // stable-sda counter
      logic       sda_q, scl_q, vs_q, sda_f;
      ddc_st_e_t  st;
      logic [3:0] bit_n;
      logic       rw, ddc_sel, sda_lo;
      logic [7:0] rd_q;
   } ddc_state_t;
   ddc_state_t s, next_s;

   logic [7:0] ram [256];   // display data store
   logic [7:0] ram_q;       // byte at pointer
   logic [7:0] ptr_m;       // pointer masked to size
   logic       smp;         // sample clock enable
   logic       start_c, stop_c, rise, fall;
   logic       on_i2c, on_vs, auto_m;
   logic [7:0] hold_w;      // active detection window
   logic       fi_valid, fi_ready, fo_valid, fo_ready;
   logic [7:0] fo_data;
   logic       ram_rd_cpu, ram_wr_cpu, hw_fetch;
   logic       addr_hit;
   logic       rise_vs;     // vsync rising edge

   // size select trims the pointer
   assign ptr_m = s.ctl[ddc_pkg::CTL_SIZE] ? s.ptr : {1'b0, s.ptr[6:0]};
   assign ram_q = ram[ptr_m];
   assign on_i2c = s.i2c_ctl[ddc_pkg::I2C_EN];
   assign on_vs  = s.ctl[ddc_pkg::CTL_VEN] && !s.ctl[ddc_pkg::CTL_MODE];
   assign auto_m = !s.ctl[ddc_pkg::CTL_SW];
   assign smp = (s.div == ddc_pkg::SAMPLE_DIV);
   // ddc path uses its own window once in i2c-ddc mode
   assign hold_w = s.ddc_sel ? s.hold_ddc : s.hold_i2c;
   // window target: 0 when disabled (one sample), else low bits
   logic [7:0] win;
   assign win = hold_w[ddc_pkg::HOLD_EN] ? {1'b0, hold_w[6:0]} : 8'h00_00;
   // conditions qualified by the hold counter
   assign start_c = s.scl_q && s.sda_f && !s.sda_q && (s.hcnt >= win) && smp;
   assign stop_c  = s.scl_q && !s.sda_f && s.sda_q && (s.hcnt >= win) && smp;
   assign rise = pins.scl && !s.scl_q;
   assign fall = !pins.scl && s.scl_q;
   // address match: own register or monitor-data address
   assign addr_hit = (s.shift[7:1] == s.own[7:1]) ||
      (s.ctl[ddc_pkg::CTL_WIDE] ? s.shift[7:4] == ddc_pkg::DDC_SLAVE[6:3]
                                : s.shift[7:1] == ddc_pkg::DDC_SLAVE);
   // cpu buffer access in any mode; the ram write lands only in software mode
   assign ram_rd_cpu = sfr.rd && sfr.addr == ddc_pkg::ADDR_RAM_BUFFER_WINDOW;
   assign ram_wr_cpu = sfr.wr && sfr.addr == ddc_pkg::ADDR_RAM_BUFFER_WINDOW;
   // automatic fetch feeds the fifo from sram
   assign hw_fetch = fi_valid && fi_ready;
   assign fi_valid = auto_m && (on_i2c || on_vs) && !ram_wr_cpu;
   assign fo_ready = 1'b0 | (next_s.st == S_TX && s.st != S_TX && auto_m)
                     | (on_vs && s.bit_n == 4'h0 && rise_vs && auto_m);
   assign rise_vs = pins.vsync && !s.vs_q;

   // prefetch fifo between sram and serialisers
   ddc_fifo #(.W(ddc_pkg::FIFO_W), .D(ddc_pkg::FIFO_D)) u_fifo (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .in_valid  (fi_valid),
      .in_ready  (fi_ready),
      .in_data   (ram_q),
      .out_valid (fo_valid),
      .out_ready (fo_ready),
      .out_data  (fo_data)
   );

   // sda is only ever pulled low; scl is never driven
   assign p4_0_out  = 1'b0;
   assign p4_0_oe_n = !s.sda_lo;
   assign irq = s.ctl[ddc_pkg::CTL_VIRQ] | s.ctl[ddc_pkg::CTL_SWIRQ]
                | s.i2c_sta[5];

   // register read mux
   always_comb begin
      unique case (sfr.addr)
         ddc_pkg::ADDR_HOLD_DDC: sfr_rdata = s.hold_ddc;
         ddc_pkg::ADDR_HOLD_I2C: sfr_rdata = s.hold_i2c;
         ddc_pkg::ADDR_RAM_BUFFER_WINDOW:   sfr_rdata = ram_q;
         ddc_pkg::ADDR_TXBYTE:   sfr_rdata = s.txb;
         ddc_pkg::ADDR_PTR:      sfr_rdata = s.ptr;
         ddc_pkg::ADDR_CTRL:     sfr_rdata = s.ctl;
         ddc_pkg::ADDR_I2C_CTL:  sfr_rdata = s.i2c_ctl;
         ddc_pkg::ADDR_I2C_STA:  sfr_rdata = s.i2c_sta;
         ddc_pkg::ADDR_I2C_DAT:  sfr_rdata = s.shift;
         ddc_pkg::ADDR_I2C_ADR:  sfr_rdata = s.own;
         default:                sfr_rdata = 8'h00_00;
      endcase
   end

   // next-state logic
   always_comb begin
      next_s = s;
      next_s.div = s.div + 1'b1;
      next_s.scl_q = pins.scl;
      next_s.vs_q  = pins.vsync;
      next_s.sda_q = pins.sda;
      // stable-sda counter on sample clocks
      if (pins.sda != s.sda_q) next_s.hcnt = 8'h00_00;
      else if (smp && s.hcnt != 8'h00_FF) next_s.hcnt = s.hcnt + 1'b1;
      if (start_c || stop_c) next_s.sda_f = s.sda_q;
      else if (smp && s.hcnt >= win) next_s.sda_f = s.sda_q;
      // pointer post-increment, cpu or hardware access
      if (ram_rd_cpu || ram_wr_cpu || hw_fetch) next_s.ptr = s.ptr + 1'b1;
      // processor register writes
      if (sfr.wr) begin
         unique case (sfr.addr)
            ddc_pkg::ADDR_HOLD_DDC: next_s.hold_ddc = sfr.wdata;
            ddc_pkg::ADDR_HOLD_I2C: next_s.hold_i2c = sfr.wdata;
            ddc_pkg::ADDR_TXBYTE:   next_s.txb = sfr.wdata;
            ddc_pkg::ADDR_PTR:      next_s.ptr = sfr.wdata;
            ddc_pkg::ADDR_CTRL: begin
               // irq bits clear on written zero only
               next_s.ctl = (sfr.wdata & ddc_pkg::CTL_WMASK)
                  | (s.ctl & sfr.wdata & 8'h00_0A) | (s.ctl & 8'h00_01);
               if (!sfr.wdata[ddc_pkg::CTL_VEN] && !on_i2c)
                  next_s.ctl[ddc_pkg::CTL_MODE] = 1'b0;
            end
            ddc_pkg::ADDR_I2C_CTL: next_s.i2c_ctl = sfr.wdata;
            ddc_pkg::ADDR_I2C_DAT: next_s.shift = sfr.wdata;
            ddc_pkg::ADDR_I2C_ADR: next_s.own = sfr.wdata;
            default: ;
         endcase
      end
      if (sfr.rd && sfr.addr == ddc_pkg::ADDR_I2C_STA)
         next_s.i2c_sta[5] = 1'b0;
      // vsync transmit-only mode shifts txb msb first
      if (on_vs && rise_vs) begin
         if (s.bit_n == 4'h0)
            next_s.txb = (auto_m && fo_valid) ? fo_data : s.txb;
         next_s.sda_lo = !((s.bit_n == 4'h0 && auto_m && fo_valid)
                           ? fo_data[7] : s.txb[7]);
         if (s.bit_n != 4'h0) next_s.txb = {s.txb[6:0], 1'b1};
         next_s.bit_n = (s.bit_n == ddc_pkg::VBITS) ? 4'h0 : s.bit_n + 1'b1;
         if (s.bit_n == ddc_pkg::VBITS && !auto_m)
            next_s.ctl[ddc_pkg::CTL_VIRQ] = 1'b1;
      end
      // i2c slave machine
      if (on_i2c) begin
         if (start_c) begin
            next_s.st = S_ADDR;
            next_s.bit_n = 4'h0;
            next_s.sda_lo = 1'b0;
         end else if (stop_c) begin
            next_s.st = S_IDLE;
            next_s.sda_lo = 1'b0;
            next_s.i2c_sta[6] = 1'b1;
         end else begin
            case (s.st)
               S_ADDR, S_RX: if (rise) begin
                  next_s.shift = {s.shift[6:0], pins.sda};
                  next_s.bit_n = s.bit_n + 1'b1;
               end else if (fall && s.bit_n == 4'h8) begin
                  next_s.bit_n = 4'h0;
                  if (s.st == S_RX) begin
                     next_s.st = S_RACK;
                     next_s.sda_lo = s.i2c_ctl[ddc_pkg::I2C_AA];
                     next_s.i2c_sta[5] = 1'b1;
                  end else if (addr_hit) begin
                     next_s.st = S_AACK;
                     next_s.sda_lo = 1'b1;
                     next_s.rw = s.shift[0];
                     next_s.ddc_sel = (s.shift[7:1] != s.own[7:1]);
                     next_s.i2c_sta[0] = 1'b1;
                     // switch to i2c mode is sticky
                     if (!s.ctl[ddc_pkg::CTL_MODE])
                        next_s.ctl[ddc_pkg::CTL_SWIRQ] = 1'b1;
                     next_s.ctl[ddc_pkg::CTL_MODE] = 1'b1;
                  end else next_s.st = S_IDLE;
               end
               S_AACK, S_RACK, S_TACK: if (fall) begin
                  next_s.sda_lo = 1'b0;
                  if (s.st == S_TACK && s.sda_q) next_s.st = S_IDLE;
                  else if (s.rw) begin
                     next_s.st = S_TX;
                     // byte from fifo or processor shift byte
                     next_s.rd_q = (auto_m && fo_valid) ? fo_data : s.shift;
                     next_s.sda_lo = !((auto_m && fo_valid)
                                       ? fo_data[7] : s.shift[7]);
                     if (!auto_m) next_s.i2c_sta[5] = 1'b1;
                  end else next_s.st = S_RX;
               end
               S_TX: if (fall) begin
                  next_s.bit_n = s.bit_n + 1'b1;
                  next_s.rd_q = {s.rd_q[6:0], 1'b1};
                  next_s.sda_lo = (s.bit_n == 4'h7) ? 1'b0 : !s.rd_q[6];
                  if (s.bit_n == 4'h7) begin
                     next_s.st = S_TACK;
                     next_s.bit_n = 4'h0;
                  end
               end
               default: ;
            endcase
         end
      end
      // leaving both modes drops the sticky mode flag
      if (!on_i2c && !s.ctl[ddc_pkg::CTL_VEN]) begin
         next_s.st = S_IDLE;
         next_s.ctl[ddc_pkg::CTL_MODE] = 1'b0;
      end
   end

   // state and sram registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s <= '0;
         s.sda_q <= 1'b1;
         s.sda_f <= 1'b1;
         s.scl_q <= 1'b1;
      end else begin
         s <= next_s;
      end
      if (ram_wr_cpu && !auto_m) ram[ptr_m] <= sfr.wdata;
   end

   a_ptr_post_inc: assert property (@(posedge mclk) disable iff (sys_rst)
      (ram_rd_cpu && !sfr.wr) |=> s.ptr == $past(s.ptr) + 8'h00_01)
      else $error("pointer did not advance");
   a_mode_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
      (s.ctl[0] && on_i2c) |=> s.ctl[0]) else $error("mode dropped");
   a_sda_only_low: assert property (@(posedge mclk) disable iff (sys_rst)
      p4_0_out == 1'b0) else $error("sda driven high");
   a_hold_reset: assert property (@(posedge mclk)
      $past(sys_rst) |-> s.hold_ddc == 8'h00_00 && s.txb == 8'h00_00)
      else $error("reset value wrong");
   a_vsync_off: assert property (@(posedge mclk) disable iff (sys_rst)
      (!on_vs && !on_i2c && !s.sda_lo) |=> !s.sda_lo)
      else $error("sda moved while idle");
   a_start_window: assert property (@(posedge mclk) disable iff (sys_rst)
      start_c |-> s.hcnt >= win) else $error("start too short");
   a_size_small: assert property (@(posedge mclk) disable iff (sys_rst)
      !s.ctl[6] |-> !ptr_m[7]) else $error("pointer over 128");
   a_addr_ack: assert property (@(posedge mclk) disable iff (sys_rst)
      (s.st == S_ADDR && next_s.st == S_AACK) |=> s.sda_lo)
      else $error("address not acknowledged");
endmodule : ddc_slave

// ===== verif/ddc_host_model.sv
/*
 * ddc_host_model: display host on the far side of the serial link,
 * acting as bus master with open-drain data and a pulled-up line.
 * assumes the bench calls its tasks and that mclk is the slave clock.
 */
module ddc_host_model #(
   parameter int HB = 20               // mclk cycles per bit phase
) (
   input  wire logic mclk,
   input  wire logic p4_0_oe_n,        // slave pulls data low when 0
   output logic      scl,              // host-made clock, idle high
   output logic      sda_line          // resolved data wire
);
   logic sda_drv;                      // host side of open drain

   // pull-up: either party may hold the line low
   assign sda_line = sda_drv & p4_0_oe_n;

   initial begin
      scl     = 1'b1;                  // clock stands still between frames
      sda_drv = 1'b1;
   end

   // all changes just after a falling edge, well clear of sampling
   task automatic wait_n(input int n);
      repeat (n) @(negedge mclk);
   endtask : wait_n

   // data falls with clock high, held longer than the hold window
   task automatic start_cond;
      sda_drv = 1'b1;
      scl     = 1'b1;
      wait_n(HB);
      sda_drv = 1'b0;
      wait_n(HB);
      scl = 1'b0;
      wait_n(HB);
   endtask : start_cond

   // data rises with clock high, then the bus is left idle
   task automatic stop_cond;
      sda_drv = 1'b0;
      wait_n(HB);
      scl = 1'b1;
      wait_n(HB);
      sda_drv = 1'b1;
      wait_n(HB);
   endtask : stop_cond

   // one bit: data set while clock low, wire sampled late in high phase
   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      wait_n(HB);
      scl = 1'b1;
      wait_n(HB);
      r   = sda_line;
      scl = 1'b0;
      wait_n(HB);
   endtask : bit_io

   // msb first; sending ff releases the wire for a slave read
   task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      sda_drv = 1'b1;
   endtask : byte_io
endmodule : ddc_host_model

// ===== verif/display_data_channel_slave_tb.sv
/*
 * display_data_channel_slave_tb: self-checking bench for ddc_slave,
 * register port driven on falling edges, host model on the link.
 * assumes the package constants and the hand-over timing of ddc_slave.
 */
module display_data_channel_slave_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic                  mclk;        // 200 MHz system clock
   logic                  sys_rst;     // synchronous, active high
   ddc_pkg::ddc_sfr_req_t sfr;         // register request
   logic [7:0]            sfr_rdata;   // register read data
   logic                  scl;         // from host
   logic                  sda_line;    // resolved wire
   logic                  p4_0_out;    // slave data level
   logic                  p4_0_oe_n;   // slave drives when low
   logic                  irq;         // event request
   ddc_pkg::ddc_pins_t    pins;        // port4 pin samples
   int                    mismatches;  // failed comparisons
   int                    n_compared;  // all comparisons
   int                    cycles;      // hang guard

   // vsync held low: the transmit-only mode is not exercised here
   assign pins = '{sda: sda_line, scl: scl, vsync: 1'b0};

   ddc_slave ddc_slave_inst (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .sfr       (sfr),
      .sfr_rdata (sfr_rdata),
      .pins      (pins),
      .p4_0_out  (p4_0_out),
      .p4_0_oe_n (p4_0_oe_n),
      .irq       (irq)
   );

   ddc_host_model #(.HB(20)) ddc_host_model_inst (
      .mclk      (mclk),
      .p4_0_oe_n (p4_0_oe_n),
      .scl       (scl),
      .sda_line  (sda_line)
   );

   // clock, 5 ns period
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // hang guard, far above the expected few thousand cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         mismatches = mismatches + 1;
         tally_and_finish();
      end
   end

   // single place where the run ends
   task automatic tally_and_finish;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // byte comparison, four-state exact
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk8

   // one-cycle write pulse, taken at the rising edge inside
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge mclk);
      sfr = '0;
   endtask : sfr_wr

   // read mux is combinational: sample before the taking edge
   task automatic sfr_chk(input logic [7:0] a, input logic [7:0] exp,
                          input logic [7:0] mask);
      sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00_00};
      #1;
      chk8(sfr_rdata & mask, exp);
      @(negedge mclk);
      sfr = '0;
   endtask : sfr_chk

   // start plus address byte; returns the wire level in the ack slot
   task automatic i2c_addr(input logic [7:0] a, output logic ack);
      logic [7:0] rx;
      ddc_host_model_inst.start_cond();
      ddc_host_model_inst.byte_io(a, rx);
      ddc_host_model_inst.bit_io(1'b1, ack);
   endtask : i2c_addr

   // reset values and an unmapped place
   task automatic t_reset;
      logic [7:0] addrs [6] = '{8'h00_D1, 8'h00_D2, 8'h00_D5, 8'h00_D6,
                               8'h00_D7, 8'h00_D3};
      foreach (addrs[i]) sfr_chk(addrs[i], 8'h00_00, 8'h00_FF);
      chk8({7'h00, p4_0_oe_n}, 8'h00_01);
   endtask : t_reset

   // plain read/write registers hold full bytes
   task automatic t_regs;
      sfr_wr(8'h00_D1, 8'h00_8B);
      sfr_wr(8'h00_D2, 8'h00_FF);
      sfr_wr(8'h00_D5, 8'h00_A5);
      sfr_chk(8'h00_D1, 8'h00_8B, 8'h00_FF);
      sfr_chk(8'h00_D2, 8'h00_FF, 8'h00_FF);
      sfr_chk(8'h00_D5, 8'h00_A5, 8'h00_FF);
      sfr_wr(8'h00_D7, 8'h00_FF);
      sfr_chk(8'h00_D7, 8'h00_74, 8'h00_FF);
   endtask : t_regs

   // pointer wraps at the top, back-to-back buffer accesses
   task automatic t_pointer;
      sfr_wr(8'h00_D7, 8'h00_60);
      sfr_wr(8'h00_D6, 8'h00_FE);
      sfr_wr(8'h00_D4, 8'h00_AA);
      sfr_chk(8'h00_D6, 8'h00_FF, 8'h00_FF);
      sfr_wr(8'h00_D4, 8'h00_55);
      sfr_chk(8'h00_D6, 8'h00_00, 8'h00_FF);
      sfr_wr(8'h00_D6, 8'h00_FE);
      sfr_chk(8'h00_D4, 8'h00_AA, 8'h00_FF);
      sfr_chk(8'h00_D4, 8'h00_55, 8'h00_FF);
      sfr_chk(8'h00_D6, 8'h00_00, 8'h00_FF);
      // write with software mode off must not land in the ram
      sfr_wr(8'h00_D7, 8'h00_40);
      sfr_wr(8'h00_D6, 8'h00_FE);
      sfr_wr(8'h00_D4, 8'h00_11);
      sfr_wr(8'h00_D7, 8'h00_60);
      sfr_wr(8'h00_D6, 8'h00_FE);
      sfr_chk(8'h00_D4, 8'h00_AA, 8'h00_FF);
   endtask : t_pointer

   // automatic read by the host, two bytes then nack
   task automatic t_i2c_read;
      logic       a;
      logic [7:0] rx;
      sfr_wr(8'h00_D6, 8'h00_00);
      sfr_wr(8'h00_D4, 8'h00_12);
      sfr_wr(8'h00_D4, 8'h00_34);
      sfr_wr(8'h00_D1, 8'h00_83);      // 4 sample clocks, 8 mclk
      sfr_wr(8'h00_D2, 8'h00_83);      // start seen before first match
      sfr_wr(8'h00_D7, 8'h00_40);
      sfr_wr(8'h00_D6, 8'h00_00);
      sfr_wr(8'h00_D8, 8'h00_44);
      i2c_addr({ddc_pkg::DDC_SLAVE, 1'b1}, a);
      chk8({7'h00, a}, 8'h00_00);
      ddc_host_model_inst.byte_io(8'h00_FF, rx);
      chk8(rx, 8'h00_12);
      ddc_host_model_inst.bit_io(1'b0, a);
      ddc_host_model_inst.byte_io(8'h00_FF, rx);
      chk8(rx, 8'h00_34);
      ddc_host_model_inst.bit_io(1'b1, a);
      ddc_host_model_inst.stop_cond();
      sfr_chk(8'h00_D7, 8'h00_01, 8'h00_01);
      chk8({7'h00, p4_0_out}, 8'h00_00);
      chk8({7'h00, irq}, 8'h00_01);
   endtask : t_i2c_read

   // foreign address unanswered, then answered under wide match
   task automatic t_address;
      logic a;
      i2c_addr(8'h00_A4, a);
      chk8({7'h00, a}, 8'h00_01);
      ddc_host_model_inst.stop_cond();
      sfr_wr(8'h00_D7, 8'h00_50);
      i2c_addr(8'h00_A4, a);
      chk8({7'h00, a}, 8'h00_00);
      ddc_host_model_inst.stop_cond();
      sfr_chk(8'h00_D7, 8'h00_01, 8'h00_01);
      chk8({7'h00, irq}, 8'h00_00);
   endtask : t_address

   // main sequence: inputs set at time zero, reset 12 cycles
   initial begin
      mismatches = 0;
      n_compared = 0;
      cycles     = 0;
      sfr        = '0;
      sys_rst    = 1'b1;
      repeat (12) @(negedge mclk);
      sys_rst = 1'b0;
      @(negedge mclk);
      t_reset();
      t_regs();
      t_pointer();
      t_i2c_read();
      t_address();
      tally_and_finish();
   end
endmodule : display_data_channel_slave_tb
